// >>> shared/itcb_pkg.sv
// package for the data break sequencer and its peripheral-side partner
// assumes a 25 MHz clock; the RTL cycle timing derived from the localparams here (checker and bench use literals)
package itcb_pkg;
  // ----------------------------------------
  // word layout and timing
  // ----------------------------------------
  localparam int ITCB_WIDTH = 12;         // bit 11 is msb, bit 0 lsb
  localparam int ITCB_CLK_NS = 40;        // clock period
  localparam int ITCB_CYCLE_NS = 1600;    // one memory cycle
  localparam int ITCB_CYCLE_CLKS = ITCB_CYCLE_NS / ITCB_CLK_NS;
  localparam int ITCB_TP1_CLK = 0;        // phase-one pulse slot in a cycle
  localparam int ITCB_TP2_CLK = 22;       // phase-two pulse slot (read done)
  localparam int ITCB_LEAD_NS = 250;      // increment request setup before phase two
  localparam int ITCB_LEAD_CLKS = (ITCB_LEAD_NS + ITCB_CLK_NS - 1) / ITCB_CLK_NS;
  localparam int ITCB_MEM_WORDS = 4096;
  localparam logic [11:0] ITCB_ZERO = 12'h000;
  localparam logic [11:0] ITCB_ONE = 12'h001;
  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  typedef enum logic [2:0] {
    ITCB_IDLE,
    ITCB_WORD_COUNT,
    ITCB_CURRENT_ADDRESS,
    ITCB_BREAK
  } itcb_state_type;
endpackage

// >>> shared/itcb_if.sv
// interface joining the processor break sequencer and the device interface
// levels are active high logic here; the pin polarity is a board matter
`timescale 1ns/1ps
interface itcb_if;
  logic [11:0] data_address;       // device-given address
  logic direction_in;              // 1 device-to-processor, 0 processor-to-device
  logic three_cycle;               // 1 three-cycle, 0 single-cycle break
  logic break_request;             // device wants a break
  logic buffer_increment_request;  // memory increment break
  logic pointer_hold_request;      // keep current address unchanged
  logic [11:0] data_in;            // device data for input transfers
  logic [11:0] data_out;           // memory buffer content to device
  logic break_active;              // break cycle in progress
  logic address_accepted;          // pulse at end of cycle before break
  logic phase_one_time_pulse;      // one-clock pulse per memory cycle
  logic phase_two_time_pulse;      // one-clock pulse per memory cycle
  logic count_completion_level;    // word count reached zero
  modport proc (
    input data_address, direction_in, three_cycle, break_request,
    input buffer_increment_request, pointer_hold_request, data_in,
    output data_out, break_active, address_accepted,
    output phase_one_time_pulse, phase_two_time_pulse, count_completion_level
  );
  modport dev (
    output data_address, direction_in, three_cycle, break_request,
    output buffer_increment_request, pointer_hold_request, data_in,
    input data_out, break_active, address_accepted,
    input phase_one_time_pulse, phase_two_time_pulse, count_completion_level
  );
endinterface

// >>> rtl/itcb_cycle_timer.sv
// memory cycle timer: slot counter with phase pulses
// assumes one clock; the slot count is the memory cycle length in clocks
`timescale 1ns/1ps
module itcb_cycle_timer
  import itcb_pkg::*;
#(
  parameter int CYCLE_CLKS = ITCB_CYCLE_CLKS
) (
  input wire logic clk_i,          // system clock
  input wire logic rst_i,          // async reset, high
  output logic tp1_o,              // phase-one slot pulse
  output logic tp2_o,              // phase-two slot pulse
  output logic end_o               // last slot of the cycle
);
  // refuse cycle lengths that leave no slot after phase two or exceed 255 for the 8-bit slot counter
  if (CYCLE_CLKS <= ITCB_TP2_CLK + 1 || CYCLE_CLKS > 255) begin : g_bad_cycle
    $error("bad cycle length");
  end
  logic [7:0] slot_q;
  wire last_w = (slot_q == 8'(CYCLE_CLKS - 1));
  // ----------------------------------------
  // slot counter
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      slot_q <= 8'h00;
    end else begin
      slot_q <= last_w ? 8'h00 : slot_q + 8'h01;
    end
  end
  assign tp1_o = (slot_q == 8'(ITCB_TP1_CLK));
  assign tp2_o = (slot_q == 8'(ITCB_TP2_CLK));
  assign end_o = last_w;
endmodule

// >>> rtl/itcb_processor.sv
// processor-side data break sequencer with its own core memory array
// assumes the device levels are static and synchronous to clk_i
//
// Functional notes
// - increment break reads, adds one, rewrites
// - device requests increment, gives no strobe
// - device drives address, direction, type, request
// - increment request stands 250 ns before phase two
// - device gates increment with break, output direction
// - increment request forces carry at phase two
// - shared three-cycle rate stays under 208 kc
// - three-cycle break takes fixed count address
// - count location incremented; zero signals completion
// - count of minus N completes on Nth
// - pointer read, incremented, used as address
// - pointer hold rewrites pointer unchanged
// - pointer loads address register, then transfer
// - mixed break devices need own channels
// - completion level high phase two to phase two
// - three-cycle type enters word count first
// - count address is even
// - pointer location is count address with lsb set
// - direction low output, high input
// - request dropped before phase one: one cycle
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/1ps
module itcb_processor
  import itcb_pkg::*;
#(
  parameter int WIDTH = ITCB_WIDTH,
  parameter int WORDS = ITCB_MEM_WORDS
) (
  input wire logic clk_i,          // system clock
  input wire logic rst_i,          // async reset, high
  itcb_if.proc link,               // device side
  input wire logic [11:0] sw_addr_i, // software port address
  input wire logic [11:0] sw_wdata_i, // software write data
  input wire logic sw_write_i,     // software write strobe
  input wire logic sw_read_i,      // software read strobe
  output logic [11:0] sw_rdata_o,  // read data, one cycle later
  output logic [2:0] state_o       // sequencer state
);
  // only a 12-bit, 4096-word core is served
  if (WIDTH != 12 || WORDS != 4096) begin : g_bad_size
    $error("sequencer serves 12-bit, 4096-word memory only");
  end
  // ----------------------------------------
  // core memory and cycle timing
  // ----------------------------------------
  logic [11:0] mem [WORDS];
  logic tp1_w, tp2_w, end_w;
  itcb_cycle_timer u_timer (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .tp1_o(tp1_w),
    .tp2_o(tp2_w),
    .end_o(end_w)
  );
  itcb_state_type state_q, state_d;
  logic [11:0] memory_address_register_q;
  logic [11:0] memory_buffer_register_q;
  logic [11:0] count_addr_q;
  logic count_completion_q, completion_pending_q;
  logic tp1_q, tp2_q, accepted_q, active_q;
  logic [11:0] data_out_q, sw_rdata_q;
  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire in_break_w = (state_q != ITCB_IDLE);
  wire [11:0] read_word_w = mem[memory_address_register_q];
  wire incr_w = link.buffer_increment_request && !link.direction_in;
  wire [11:0] plus_one_w = read_word_w + ITCB_ONE;
  wire [11:0] pointer_addr_w = {count_addr_q[11:1], 1'b1};
  wire [11:0] next_pointer_w = link.pointer_hold_request ? read_word_w : plus_one_w;
  wire more_w = link.break_request;
  // ----------------------------------------
  // next state at end of each memory cycle
  // ----------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      ITCB_IDLE: begin
        if (more_w) begin
          state_d = link.three_cycle ? ITCB_WORD_COUNT : ITCB_BREAK;
        end
      end
      ITCB_WORD_COUNT: begin
        state_d = ITCB_CURRENT_ADDRESS;
      end
      ITCB_CURRENT_ADDRESS: begin
        state_d = ITCB_BREAK;
      end
      default: begin
        if (!more_w) begin
          state_d = ITCB_IDLE;
        end else begin
          state_d = link.three_cycle ? ITCB_WORD_COUNT : ITCB_BREAK;
        end
      end
    endcase
  end
  // ----------------------------------------
  // sequencer and address register
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      state_q <= ITCB_IDLE;
      memory_address_register_q <= ITCB_ZERO;
      count_addr_q <= ITCB_ZERO;
      accepted_q <= 1'b0;
    end else begin
      accepted_q <= end_w && more_w && (state_d == ITCB_BREAK || state_d == ITCB_WORD_COUNT)
                    && state_q != ITCB_WORD_COUNT;
      if (end_w) begin
        state_q <= state_d;
        if (state_d == ITCB_WORD_COUNT) begin
          memory_address_register_q <= link.data_address;
          count_addr_q <= link.data_address;
        end else if (state_d == ITCB_CURRENT_ADDRESS) begin
          memory_address_register_q <= pointer_addr_w;
        end else if (state_d == ITCB_BREAK && state_q == ITCB_CURRENT_ADDRESS) begin
          memory_address_register_q <= memory_buffer_register_q;
        end else if (state_d == ITCB_BREAK) begin
          memory_address_register_q <= link.data_address;
        end
      end
    end
  end
  // ----------------------------------------
  // memory buffer: read and modify at phase two
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      memory_buffer_register_q <= ITCB_ZERO;
      completion_pending_q <= 1'b0;
    end else if (tp2_w && in_break_w) begin
      completion_pending_q <= 1'b0;
      case (state_q)
        ITCB_WORD_COUNT: begin
          memory_buffer_register_q <= plus_one_w;
          completion_pending_q <= (plus_one_w == ITCB_ZERO);
        end
        ITCB_CURRENT_ADDRESS: memory_buffer_register_q <= next_pointer_w;
        default: begin
          if (link.direction_in) begin
            memory_buffer_register_q <= link.data_in;
          end else begin
            memory_buffer_register_q <= incr_w ? plus_one_w : read_word_w;
          end
        end
      endcase
    end else if (tp2_w) begin
      completion_pending_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // rewrite in the last half of the cycle; software port when idle
  // ----------------------------------------
  always_ff @(posedge clk_i) begin
    if (end_w && in_break_w) begin
      mem[memory_address_register_q] <= memory_buffer_register_q;
    end else if (sw_write_i && !in_break_w) begin
      mem[sw_addr_i] <= sw_wdata_i;
    end
  end
  // ----------------------------------------
  // registered outputs
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      count_completion_q <= 1'b0;
      tp1_q <= 1'b0;
      tp2_q <= 1'b0;
      active_q <= 1'b0;
      data_out_q <= ITCB_ZERO;
      sw_rdata_q <= ITCB_ZERO;
    end else begin
      tp1_q <= tp1_w;
      tp2_q <= tp2_w;
      active_q <= in_break_w;
      data_out_q <= memory_buffer_register_q;
      sw_rdata_q <= sw_read_i ? mem[sw_addr_i] : ITCB_ZERO;
      if (tp2_q) begin
        count_completion_q <= completion_pending_q;
      end
    end
  end
  assign link.count_completion_level = count_completion_q;
  assign link.phase_one_time_pulse = tp1_q;
  assign link.phase_two_time_pulse = tp2_q;
  assign link.address_accepted = accepted_q;
  assign link.break_active = active_q;
  assign link.data_out = data_out_q;
  assign sw_rdata_o = sw_rdata_q;
  assign state_o = state_q;
endmodule

// >>> rtl/itcb_device.sv
// peripheral-side data break interface: holds static levels for the sequencer
// assumes user commands are taken while no break is requested
`timescale 1ns/1ps
module itcb_device
  import itcb_pkg::*;
(
  input wire logic clk_i,          // system clock
  input wire logic rst_i,          // async reset, high
  itcb_if.dev link,                // processor side, own channel
  input wire logic start_i,        // pulse: begin one break
  input wire logic [11:0] addr_i,  // address or count location
  input wire logic [11:0] wdata_i, // data for input transfer
  input wire logic dir_in_i,       // 1 input, 0 output transfer
  input wire logic three_cycle_i,  // use three-cycle break
  input wire logic incr_i,         // memory increment wanted
  input wire logic hold_i,         // keep pointer unchanged
  input wire logic more_i,         // keep requesting after this break
  output logic busy_o,             // request outstanding
  output logic [11:0] rdata_o,     // strobed output word
  output logic rdata_valid_o,      // pulse: rdata_o updated
  output logic done_o              // count completion seen
);
  logic req_q, dir_q, three_q, incr_q, hold_q, more_q;
  logic [11:0] addr_q, wdata_q, rdata_q;
  logic valid_q, done_q, strobe_q;
  logic [1:0] step_q;
  // only the last of the three break cycles carries the data word
  wire xfer_w = !three_q || (step_q == 2'h2);
  // ----------------------------------------
  // request levels
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      req_q <= 1'b0;
      dir_q <= 1'b0;
      three_q <= 1'b0;
      incr_q <= 1'b0;
      hold_q <= 1'b0;
      more_q <= 1'b0;
      addr_q <= ITCB_ZERO;
      wdata_q <= ITCB_ZERO;
    end else if (start_i && !req_q) begin
      req_q <= 1'b1;
      dir_q <= dir_in_i && !incr_i;
      three_q <= three_cycle_i;
      incr_q <= incr_i && !three_cycle_i;
      hold_q <= hold_i;
      more_q <= more_i;
      addr_q <= three_cycle_i ? {addr_i[11:1], 1'b0} : addr_i;
      wdata_q <= wdata_i;
    end else if (link.address_accepted && !more_q) begin
      req_q <= 1'b0;
    end
  end
  // ----------------------------------------
  // output strobe in break cycle, not for increments
  // ----------------------------------------
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      strobe_q <= 1'b0;
      valid_q <= 1'b0;
      rdata_q <= ITCB_ZERO;
      done_q <= 1'b0;
      step_q <= 2'h0;
    end else begin
      strobe_q <= link.phase_two_time_pulse;
      valid_q <= 1'b0;
      // count phase-two pulses within a break to find the transfer cycle
      if (!link.break_active) begin
        step_q <= 2'h0;
      end else if (strobe_q) begin
        step_q <= (step_q == 2'h2) ? 2'h0 : step_q + 2'h1;
      end
      if (strobe_q && link.break_active && xfer_w && !dir_q && !incr_q) begin
        rdata_q <= link.data_out;
        valid_q <= 1'b1;
      end
      if (start_i && !req_q) begin
        done_q <= 1'b0;
      end else if (link.count_completion_level) begin
        done_q <= 1'b1;
      end
    end
  end
  assign link.break_request = req_q;
  assign link.direction_in = dir_q;
  assign link.three_cycle = three_q;
  assign link.data_address = addr_q;
  assign link.data_in = wdata_q;
  assign link.pointer_hold_request = hold_q && three_q;
  // up with break_active at slot 1, long before phase two
  assign link.buffer_increment_request = incr_q && !dir_q && link.break_active;
  assign busy_o = req_q;
  assign rdata_o = rdata_q;
  assign rdata_valid_o = valid_q;
  assign done_o = done_q;
endmodule

// >>> tb/itcb_chk.sv
// checker on the signals between the break sequencer and the device side
// assumes one clock domain and an active-high asynchronous reset
`timescale 1ns/1ps
module itcb_chk (
  input wire logic clk_i,                  // system clock
  input wire logic rst_i,                  // reset, high
  input wire logic three_cycle,            // three-cycle select
  input wire logic break_request,          // device request
  input wire logic address_accepted,       // accept pulse
  input wire logic break_active,           // break cycle level
  input wire logic phase_one_time_pulse,   // phase one
  input wire logic phase_two_time_pulse,   // phase two
  input wire logic count_completion_level  // count done
);
  // ------
  // timing sequences
  // ------
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_mem_cycle;
    phase_one_time_pulse ##22 phase_two_time_pulse ##18 phase_one_time_pulse;
  endsequence
  sequence s_compl_hold;
    count_completion_level ##39 count_completion_level ##1 !count_completion_level;
  endsequence
  // ------
  // assertions
  // ------
  AST_MEM_CYCLE: assert property (phase_one_time_pulse |-> s_mem_cycle)
    else $error("memory cycle pulses misplaced");
  AST_COMPL_AFTER_TP2: assert property ($rose(count_completion_level) |-> $past(phase_two_time_pulse))
    else $error("completion rose away from phase two");
  AST_COMPL_PERIOD: assert property ($rose(count_completion_level) |-> s_compl_hold)
    else $error("completion level length wrong");
  AST_COMPL_THREE: assert property ($rose(count_completion_level) |-> three_cycle)
    else $error("completion outside three-cycle break");
  AST_ACCEPT_PULSE: assert property (address_accepted |=> !address_accepted)
    else $error("accept pulse too long");
  AST_ACCEPT_REQ: assert property (address_accepted |-> break_request)
    else $error("accept without request");
  AST_ACCEPT_BREAK: assert property (address_accepted && !three_cycle |=> break_active)
    else $error("no break after accept");
  AST_ACCEPT_SLOT: assert property (address_accepted |-> ##[1:2] phase_one_time_pulse)
    else $error("accept not at cycle end");
  AST_ONE_BREAK: assert property (($rose(break_active) && !three_cycle) ##1 !break_request
    |-> ##[0:40] !break_active)
    else $error("break ran past one cycle");
  AST_ONE_BLOCK: assert property (($rose(break_active) && three_cycle) ##1 !break_request
    |-> ##[0:120] !break_active)
    else $error("block break ran past three cycles");
endmodule

// >>> tb/tb.sv
// testbench: sequencer and device joined, memory model in the bench
// assumes 25 MHz clock, software port used to preset and inspect memory
`timescale 1ns/1ps
module tb;
  import itcb_pkg::*;
  `define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin fail_count++; $display("mismatch at %0t: got %h want %h", $time, a, b); end end
  logic clk_i, rst_i, sw_write, sw_read, start, dir_in, three, incr, hold, busy, rvalid, done;
  logic [11:0] sw_addr, sw_wdata, sw_rdata, addr, wdata, rdata, got, a, v, c, p, base;
  logic [2:0] state;
  logic [11:0] mem [logic [11:0]];
  int fail_count, n_checks, i, n_strobes;
  itcb_if link ();
  itcb_processor itcb_processor_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .sw_addr_i(sw_addr),
    .sw_wdata_i(sw_wdata), .sw_write_i(sw_write), .sw_read_i(sw_read), .sw_rdata_o(sw_rdata), .state_o(state));
  itcb_device itcb_device_inst (.clk_i(clk_i), .rst_i(rst_i), .link(link), .start_i(start), .addr_i(addr),
    .wdata_i(wdata), .dir_in_i(dir_in), .three_cycle_i(three), .incr_i(incr), .hold_i(hold), .more_i(1'b0),
    .busy_o(busy), .rdata_o(rdata), .rdata_valid_o(rvalid), .done_o(done));
  itcb_chk itcb_chk_inst (.clk_i(clk_i), .rst_i(rst_i), .three_cycle(link.three_cycle),
    .break_request(link.break_request), .address_accepted(link.address_accepted),
    .break_active(link.break_active), .phase_one_time_pulse(link.phase_one_time_pulse),
    .phase_two_time_pulse(link.phase_two_time_pulse), .count_completion_level(link.count_completion_level));
  // ------
  // tasks
  // ------
  task automatic conclude();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  task automatic sw_wr(input logic [11:0] wa, input logic [11:0] wd);
    @(posedge clk_i);
    sw_addr <= wa;
    sw_wdata <= wd;
    sw_write <= 1'b1;
    @(posedge clk_i);
    sw_write <= 1'b0;
    mem[wa] = wd;
  endtask
  task automatic sw_rd(input logic [11:0] ra);
    @(posedge clk_i);
    sw_addr <= ra;
    sw_read <= 1'b1;
    @(posedge clk_i);
    sw_read <= 1'b0;
    @(negedge clk_i);
    got = sw_rdata;
  endtask
  // levels go out with the start pulse, then wait for the sequencer to go idle
  task automatic brk(input logic [11:0] ba, input logic [11:0] bd, input logic di, input logic th,
                     input logic inc, input logic hd);
    int k;
    @(posedge clk_i);
    addr <= ba;
    wdata <= bd;
    dir_in <= di;
    three <= th;
    incr <= inc;
    hold <= hd;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    k = 0;
    while (state === 3'h0 && k < 100) begin
      @(posedge clk_i);
      k++;
    end
    while (!(busy === 1'b0 && state === 3'h0) && k < 400) begin
      @(posedge clk_i);
      k++;
    end
    if (k >= 400) begin
      fail_count++;
      $display("mismatch at %0t: break hung", $time);
      conclude();
    end
  endtask
  // ------
  // clock and sequence
  // ------
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end
  // count output strobes seen at the device
  always @(posedge clk_i) begin
    if (rvalid === 1'b1) begin
      n_strobes++;
    end
  end
  // main sequence
  initial begin
    {rst_i, sw_write, sw_read, start, dir_in, three, incr, hold} = 8'h80;
    {sw_addr, sw_wdata, addr, wdata} = 48'h0;
    fail_count = 0;
    n_checks = 0;
    n_strobes = 0;
    void'($urandom(89));
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    // increment breaks, first one wraps
    for (i = 0; i < 4; i++) begin
      a = 12'($urandom);
      v = (i == 0) ? 12'hFFF : 12'($urandom);
      sw_wr(a, v);
      brk(a, 12'h000, 1'b0, 1'b0, 1'b1, 1'b0);
      mem[a] = mem[a] + 12'h001;
      sw_rd(a);
      `CHK(got, mem[a])
    end
    `CHK(n_strobes, 0)
    $display("test increment done");
    // single-cycle input then output
    a = 12'($urandom);
    v = 12'($urandom);
    brk(a, v, 1'b1, 1'b0, 1'b0, 1'b0);
    mem[a] = v;
    sw_rd(a);
    `CHK(got, mem[a])
    brk(a, 12'h000, 1'b0, 1'b0, 1'b0, 1'b0);
    `CHK(rdata, mem[a])
    `CHK(n_strobes, 1)
    sw_rd(a);
    `CHK(got, v)
    $display("test single done");
    // three-cycle block of three input words
    c = {1'b0, 10'($urandom), 1'b0};
    p = c | 12'h001;
    base = {1'b1, 11'($urandom)} & 12'hFF0;
    sw_wr(c, 12'hFFD);
    sw_wr(p, base - 12'h001);
    for (i = 0; i < 3; i++) begin
      v = 12'($urandom);
      brk(c, v, 1'b1, 1'b1, 1'b0, 1'b0);
      mem[c] = mem[c] + 12'h001;
      mem[p] = mem[p] + 12'h001;
      mem[mem[p]] = v;
      `CHK(done, (mem[c] == 12'h000))
    end
    sw_rd(c);
    `CHK(got, mem[c])
    sw_rd(p);
    `CHK(got, mem[p])
    for (i = 0; i < 3; i++) begin
      sw_rd(base + 12'(i));
      `CHK(got, mem[base + 12'(i)])
    end
    $display("test block done");
    // pointer hold, then a three-cycle output
    sw_wr(base + 12'h003, 12'($urandom));
    v = 12'($urandom);
    brk(c, v, 1'b1, 1'b1, 1'b0, 1'b1);
    mem[c] = mem[c] + 12'h001;
    mem[mem[p]] = v;
    `CHK(done, 1'b0)
    sw_rd(p);
    `CHK(got, mem[p])
    sw_rd(mem[p]);
    `CHK(got, v)
    brk(c, 12'h000, 1'b0, 1'b1, 1'b0, 1'b0);
    mem[c] = mem[c] + 12'h001;
    mem[p] = mem[p] + 12'h001;
    `CHK(rdata, mem[mem[p]])
    `CHK(n_strobes, 2)
    $display("test hold done");
    conclude();
  end
endmodule
